// ===== logic/usc_pkg.sv
// Purpose: shared constants and types of the serial clock and buffer core
// Assumes: APB slave, one clock pclk at 10 MHz
// Notes: register offsets are byte addresses of aligned 32-bit words
package usc_pkg;
    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DIV_LO = 8'h04;
    localparam logic [7:0] REG_DIV_HI = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0C;
    localparam logic [7:0] REG_STAT = 8'h10;
    // control fields
    localparam int CB_SYNC = 0;
    localparam int CB_DBL = 1;
    localparam int CB_DIR = 2;
    localparam int CB_POL = 3;
    localparam int CB_PWR = 4;
    localparam int CB_NINE = 5;
    localparam int CB_PEN = 6;
    localparam int CB_PODD = 7;
    localparam int CB_TXEN = 8;
    localparam int CB_RXEN = 9;
    localparam int CTRL_W = 10;
    localparam logic [9:0] CTRL_RESET = 10'h000;
    localparam logic [11:0] DIV_RESET = 12'h000;
    // status fields
    localparam int SB_TXE = 0;
    localparam int SB_TXC = 1;
    localparam int SB_RXC = 2;
    localparam int SB_FE = 3;
    localparam int SB_OVR = 4;
    localparam int SB_PE = 5;
    localparam int SB_B9 = 6;
    // -----------------------------------------------------------------
    // dividers and sample counts (last state index)
    // -----------------------------------------------------------------
    localparam logic [3:0] DIV_NORMAL_LAST = 4'hF;
    localparam logic [3:0] DIV_DOUBLE_LAST = 4'h7;
    localparam logic [3:0] MID_NORMAL = 4'h7;
    localparam logic [3:0] MID_DOUBLE = 4'h3;
    localparam int RX_DEPTH = 2;
    // -----------------------------------------------------------------
    // state machines
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        TX_IDLE = 3'h0,
        TX_START = 3'h1,
        TX_DATA = 3'h3,
        TX_PAR = 3'h2,
        TX_STOP = 3'h6
    } usc_tx_e;
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_DATA = 2'h1,
        RX_PAR = 2'h3,
        RX_STOP = 2'h2
    } usc_rx_e;
endpackage

// ===== logic/usc_edge_sync.sv
// Purpose: synchronise an external clock and detect its edges
// Assumes: input toggles slower than a quarter of clk
// Notes: edges appear two clk periods after the pin changes
`timescale 1ns/1ps
`default_nettype none
module usc_edge_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic rise,
    output logic fall
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // two-stage synchroniser, then one stage for the edge detector
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // edge pulses look only at the second and third stages
    assign rise = s2_r & ~s3_r;
    assign fall = ~s2_r & s3_r;
endmodule // usc_edge_sync
`default_nettype wire

// ===== logic/usc_core.sv
// Purpose: baud generator, clock modes and buffering of a serial port
// Assumes: APB slave, zero wait states, txd/rxd/xck synchronous enough
// Notes: receiver takes the frame format that the transmitter sends
`timescale 1ns/1ps
`default_nettype none
module usc_core
    import usc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic txd_out,
    input wire logic rxd_in,
    input wire logic xck_in,
    output logic xck_out,
    output logic xck_oe,
    output logic irq_tx_complete,
    output logic irq_tx_empty,
    output logic irq_rx_complete
);
    // -----------------------------------------------------------------
    // register access
    // -----------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_r;
    logic [11:0] div_r;
    logic [31:0] prdata_r;
    logic wr_en, rd_en, addr_ok, div_lo_wr, div_hi_wr, data_wr, stat_wr, pop;
    logic sync_sel, master, slave, dbl_eff, pol, pwr_off, nine;
    logic baud_tick, tx_step, rx_take, chg_edge, smp_edge;
    logic txbuf_full_r, txc_r, hold_valid_r, ovr_pend_r;
    logic [1:0] rx_cnt_r;
    logic [11:0] rx_mem_r [RX_DEPTH];
    logic rx_rp_r, rx_wp_r;
    logic [11:0] head;

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign addr_ok = (paddr == REG_CTRL) | (paddr == REG_DIV_LO) | (paddr == REG_DIV_HI)
        | (paddr == REG_DATA) | (paddr == REG_STAT);
    assign div_lo_wr = wr_en & (paddr == REG_DIV_LO);
    assign div_hi_wr = wr_en & (paddr == REG_DIV_HI);
    assign data_wr = wr_en & (paddr == REG_DATA) & ~pwr_off & ctrl_r[CB_TXEN];
    assign stat_wr = wr_en & (paddr == REG_STAT);
    assign pop = rd_en & (paddr == REG_DATA) & (rx_cnt_r != 2'h0);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata = prdata_r;
    assign head = rx_mem_r[rx_rp_r];

    // control and divisor registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RESET;
            div_r <= DIV_RESET;
        end else begin
            if (wr_en && paddr == REG_CTRL)
                ctrl_r <= pwdata[CTRL_W-1:0];
            if (div_lo_wr)
                div_r[7:0] <= pwdata[7:0];
            if (div_hi_wr)
                div_r[11:8] <= pwdata[3:0];
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_r <= 32'h0000_0000;
            case (paddr)
                REG_CTRL: prdata_r[CTRL_W-1:0] <= ctrl_r;
                REG_DIV_LO: prdata_r[7:0] <= div_r[7:0];
                REG_DIV_HI: prdata_r[3:0] <= div_r[11:8];
                REG_DATA: prdata_r[8:0] <= head[8:0];
                REG_STAT: begin
                    prdata_r[SB_TXE] <= ~txbuf_full_r;
                    prdata_r[SB_TXC] <= txc_r;
                    prdata_r[SB_RXC] <= rx_cnt_r != 2'h0;
                    prdata_r[SB_FE] <= head[9];
                    prdata_r[SB_PE] <= head[10];
                    prdata_r[SB_OVR] <= head[11];
                    prdata_r[SB_B9] <= head[8];
                end
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // clock modes
    // -----------------------------------------------------------------
    assign pwr_off = ctrl_r[CB_PWR];
    assign sync_sel = ctrl_r[CB_SYNC];
    assign master = sync_sel & ctrl_r[CB_DIR];
    assign slave = sync_sel & ~ctrl_r[CB_DIR];
    assign dbl_eff = ctrl_r[CB_DBL] & ~sync_sel;
    assign pol = ctrl_r[CB_POL];
    assign nine = ctrl_r[CB_NINE];
    assign xck_oe = master & ~pwr_off;

    // -----------------------------------------------------------------
    // baud generator
    // -----------------------------------------------------------------
    logic [11:0] bcnt_r;

    // down-counter, reloaded at zero and on a low-byte write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            bcnt_r <= DIV_RESET;
        else if (div_lo_wr)
            bcnt_r <= {div_r[11:8], pwdata[7:0]};
        else if (pwr_off)
            bcnt_r <= div_r;
        else if (bcnt_r == 12'h000)
            bcnt_r <= div_r;
        else
            bcnt_r <= bcnt_r - 12'h001;
    end

    // strobe, not a derived clock; unused in slave mode
    assign baud_tick = (bcnt_r == 12'h000) & ~pwr_off & ~slave & ~div_lo_wr;

    // -----------------------------------------------------------------
    // transfer clock: master output and slave input
    // -----------------------------------------------------------------
    logic xck_o_r, s_rise, s_fall, x_rise, x_fall;

    // master clock toggles on each tick, idles at the polarity level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            xck_o_r <= 1'b0;
        else if (!master || pwr_off)
            xck_o_r <= pol;
        else if (baud_tick)
            xck_o_r <= ~xck_o_r;
    end
    assign xck_out = xck_o_r;

    usc_edge_sync u_xck_sync (
        .clk(pclk),
        .rst_n(presetn),
        .din(xck_in),
        .rise(s_rise),
        .fall(s_fall)
    );

    // edge selection by polarity
    assign x_rise = master ? (baud_tick & ~xck_o_r) : (slave & s_rise & ~pwr_off);
    assign x_fall = master ? (baud_tick & xck_o_r) : (slave & s_fall & ~pwr_off);
    assign chg_edge = pol ? x_fall : x_rise;
    assign smp_edge = pol ? x_rise : x_fall;

    // -----------------------------------------------------------------
    // transmitter
    // -----------------------------------------------------------------
    usc_tx_e tx_state_r;
    logic [3:0] tx_pre_r, tx_bit_r;
    logic [8:0] txbuf_r, txsh_r;
    logic txd_r, tx_par_r, tx_load, tx_done;
    logic [3:0] tx_last;

    assign tx_last = dbl_eff ? DIV_DOUBLE_LAST : DIV_NORMAL_LAST;

    // async prescaler of baud ticks, 16 or 8
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            tx_pre_r <= 4'h0;
        else if (pwr_off || sync_sel)
            tx_pre_r <= 4'h0;
        else if (baud_tick)
            tx_pre_r <= (tx_pre_r >= tx_last) ? 4'h0 : tx_pre_r + 4'h1;
    end
    assign tx_step = sync_sel ? chg_edge : (baud_tick & (tx_pre_r == tx_last));
    assign tx_load = tx_step & txbuf_full_r & ((tx_state_r == TX_IDLE) | (tx_state_r == TX_STOP));
    assign tx_done = tx_step & (tx_state_r == TX_STOP) & ~txbuf_full_r;

    // write buffer ahead of the shifter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txbuf_r <= 9'h000;
            txbuf_full_r <= 1'b0;
        end else if (pwr_off) begin
            txbuf_full_r <= 1'b0;
        end else if (data_wr && !txbuf_full_r) begin
            txbuf_r <= pwdata[8:0];
            txbuf_full_r <= 1'b1;
        end else if (tx_load) begin
            txbuf_full_r <= 1'b0;
        end
    end

    // transmit done flag, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            txc_r <= 1'b0;
        else if (tx_done)
            txc_r <= 1'b1;
        else if (stat_wr && pwdata[SB_TXC])
            txc_r <= 1'b0;
    end

    // frame shifter: start, data lsb first, parity, stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_r <= TX_IDLE;
            txsh_r <= 9'h000;
            tx_bit_r <= 4'h0;
            tx_par_r <= 1'b0;
            txd_r <= 1'b1;
        end else if (pwr_off) begin
            tx_state_r <= TX_IDLE;
            txd_r <= 1'b1;
        end else if (tx_load) begin
            tx_state_r <= TX_START;
            txsh_r <= txbuf_r;
            tx_par_r <= ctrl_r[CB_PODD];
            tx_bit_r <= 4'h0;
            txd_r <= 1'b0;
        end else if (tx_step) begin
            case (tx_state_r)
                TX_START, TX_DATA: begin
                    if (tx_state_r == TX_DATA && tx_bit_r == (nine ? 4'h9 : 4'h8)) begin
                        tx_state_r <= ctrl_r[CB_PEN] ? TX_PAR : TX_STOP;
                        txd_r <= ctrl_r[CB_PEN] ? tx_par_r : 1'b1;
                    end else begin
                        tx_state_r <= TX_DATA;
                        txd_r <= txsh_r[0];
                        tx_par_r <= tx_par_r ^ txsh_r[0];
                        txsh_r <= {1'b0, txsh_r[8:1]};
                        tx_bit_r <= tx_bit_r + 4'h1;
                    end
                end
                TX_PAR: begin
                    tx_state_r <= TX_STOP;
                    txd_r <= 1'b1;
                end
                TX_STOP: begin
                    tx_state_r <= TX_IDLE;
                    txd_r <= 1'b1;
                end
                default: begin
                    tx_state_r <= TX_IDLE;
                    txd_r <= 1'b1;
                end
            endcase
        end
    end
    assign txd_out = txd_r;

    // -----------------------------------------------------------------
    // receiver recovery
    // -----------------------------------------------------------------
    usc_rx_e rx_state_r;
    logic [3:0] rx_sc_r, rx_bit_r, rx_last, rx_mid;
    logic [8:0] rxsh_r, hold_data_r;
    logic rx_par_r, pe_r, hold_fe_r, hold_pe_r, rx_on, new_start, push, drop;

    assign rx_on = ~pwr_off & ctrl_r[CB_RXEN];
    assign rx_last = dbl_eff ? DIV_DOUBLE_LAST : DIV_NORMAL_LAST;
    assign rx_mid = dbl_eff ? MID_DOUBLE : MID_NORMAL;

    // async sample counter on raw ticks; sync uses the two clock phases
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rx_sc_r <= 4'h0;
        else if (!rx_on || sync_sel)
            rx_sc_r <= 4'h0;
        else if (rx_state_r == RX_IDLE && rxd_in)
            rx_sc_r <= 4'h0;
        else if (baud_tick)
            rx_sc_r <= (rx_sc_r >= rx_last) ? 4'h0 : rx_sc_r + 4'h1;
    end
    assign rx_take = sync_sel ? smp_edge : (baud_tick & (rx_sc_r == rx_mid));
    assign new_start = rx_on & rx_take & (rx_state_r == RX_IDLE) & ~rxd_in;

    // frame receiver; a high start sample is a false start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_r <= RX_IDLE;
            rxsh_r <= 9'h000;
            rx_bit_r <= 4'h0;
            rx_par_r <= 1'b0;
            pe_r <= 1'b0;
        end else if (!rx_on) begin
            rx_state_r <= RX_IDLE;
        end else if (rx_take) begin
            case (rx_state_r)
                RX_IDLE: begin
                    if (!rxd_in) begin
                        rx_state_r <= RX_DATA;
                        rx_bit_r <= 4'h0;
                        rx_par_r <= ctrl_r[CB_PODD];
                        pe_r <= 1'b0;
                    end
                end
                RX_DATA: begin
                    rxsh_r <= {rxd_in, rxsh_r[8:1]};
                    rx_par_r <= rx_par_r ^ rxd_in;
                    rx_bit_r <= rx_bit_r + 4'h1;
                    if (rx_bit_r == (nine ? 4'h8 : 4'h7))
                        rx_state_r <= ctrl_r[CB_PEN] ? RX_PAR : RX_STOP;
                end
                RX_PAR: begin
                    pe_r <= rx_par_r ^ rxd_in;
                    rx_state_r <= RX_STOP;
                end
                RX_STOP: rx_state_r <= RX_IDLE;
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // shifter as third level and two-entry receive FIFO
    // -----------------------------------------------------------------
    assign push = hold_valid_r & (rx_cnt_r != 2'h2);
    assign drop = new_start & hold_valid_r & (rx_cnt_r == 2'h2) & ~pop;

    // completed frame waits here while the FIFO is full
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_valid_r <= 1'b0;
            hold_data_r <= 9'h000;
            hold_fe_r <= 1'b0;
            hold_pe_r <= 1'b0;
        end else if (!rx_on) begin
            hold_valid_r <= 1'b0;
        end else if (rx_take && rx_state_r == RX_STOP) begin
            hold_valid_r <= 1'b1;
            hold_data_r <= nine ? rxsh_r : {1'b0, rxsh_r[8:1]};
            hold_fe_r <= ~rxd_in;
            hold_pe_r <= pe_r;
        end else if (push || drop) begin
            hold_valid_r <= 1'b0;
        end
    end

    // overrun noted on the next entry that enters the FIFO
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ovr_pend_r <= 1'b0;
        else if (drop)
            ovr_pend_r <= 1'b1;
        else if (push)
            ovr_pend_r <= 1'b0;
    end

    // circular FIFO with status stored beside the data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_wp_r <= 1'b0;
            rx_rp_r <= 1'b0;
            rx_cnt_r <= 2'h0;
            for (int i = 0; i < RX_DEPTH; i++)
                rx_mem_r[i] <= 12'h000;
        end else begin
            if (push) begin
                rx_mem_r[rx_wp_r] <= {ovr_pend_r, hold_pe_r, hold_fe_r, hold_data_r};
                rx_wp_r <= ~rx_wp_r;
            end
            if (pop)
                rx_rp_r <= ~rx_rp_r;
            rx_cnt_r <= rx_cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // interrupt request levels
    assign irq_tx_complete = txc_r;
    assign irq_tx_empty = ~txbuf_full_r & ctrl_r[CB_TXEN] & ~pwr_off;
    assign irq_rx_complete = rx_cnt_r != 2'h0;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    logic [11:0] gap_r;
    logic clean_r;

    // cycles since the last tick, valid while the divisor held still
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_r <= 12'h000;
            clean_r <= 1'b0;
        end else begin
            gap_r <= baud_tick ? 12'h000 : gap_r + 12'h001;
            if (div_lo_wr || div_hi_wr || pwr_off || slave)
                clean_r <= 1'b0;
            else if (baud_tick)
                clean_r <= 1'b1;
        end
    end

    chk_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
        baud_tick && clean_r |-> gap_r == div_r)
        else $error("baud tick period differs from divisor plus one");
    chk_baud_reload: assert property (@(posedge pclk) disable iff (!presetn)
        baud_tick |=> bcnt_r == $past(div_r))
        else $error("counter not reloaded with divisor at zero");
    chk_tx_divide: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_step && !sync_sel) |-> baud_tick && tx_pre_r == (dbl_eff ? 4'h7 : 4'hF))
        else $error("async transmit step not at divider end");
    chk_pin_unused: assert property (@(posedge pclk) disable iff (!presetn)
        !sync_sel |-> !xck_oe && !x_rise && !x_fall)
        else $error("transfer clock active outside sync mode");
    chk_sync_nodbl: assert property (@(posedge pclk) disable iff (!presetn)
        sync_sel |-> !dbl_eff && (tx_pre_r == 4'h0 || !$past(sync_sel)))
        else $error("double speed affects sync mode");
    chk_slave_lat: assert property (@(posedge pclk) disable iff (!presetn)
        (slave && !pwr_off && !pol && $rose(xck_in))[*1] ##1 (slave && !pwr_off && !pol)[*1]
        |-> ##1 chg_edge)
        else $error("slave clock edge not seen two cycles later");
    chk_fifo_depth: assert property (@(posedge pclk) disable iff (!presetn)
        (rx_cnt_r <= 2'h2) and (pop |=> rx_cnt_r == $past(rx_cnt_r) - {1'b0, !$past(push)}))
        else $error("receive FIFO depth or pop wrong");
    chk_third_level: assert property (@(posedge pclk) disable iff (!presetn)
        hold_valid_r && rx_cnt_r == 2'h2 && !pop && !new_start && rx_on |=> hold_valid_r)
        else $error("held frame lost without a new start");
    chk_power_off: assert property (@(posedge pclk) disable iff (!presetn)
        pwr_off && $past(pwr_off) |-> tx_state_r == TX_IDLE && !baud_tick && !xck_oe && txd_out)
        else $error("block active while powered off");
    chk_back_to_back: assert property (@(posedge pclk) disable iff (!presetn)
        tx_step && tx_state_r == TX_STOP && txbuf_full_r && !pwr_off
        |=> tx_state_r == TX_START && !txd_out)
        else $error("gap between buffered frames");
endmodule // usc_core
`default_nettype wire

// ===== test/usc_remote.sv
// Purpose: remote serial sender on the line
// Assumes: async frame, 8 data bits, no parity
// Notes: xck idles low and toggles only when asked
`timescale 1ns/1ps
`default_nettype none
module usc_remote (
    input wire logic clk,
    output logic rxd,
    output logic transfer_clock_pin
);
    // idle line high, clock still
    initial begin
        rxd = 1'b1;
        transfer_clock_pin = 1'b0;
    end
    // one frame lsb first, n cycles a bit
    task automatic send(input logic [7:0] d, input int n);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (n) @(posedge clk);
        end
    endtask
    // slave transfer clock, p periods of 2*h cycles, ends low
    task automatic clocks(input int p, input int h);
        for (int i = 0; i < 2 * p; i++) begin
            transfer_clock_pin <= ~transfer_clock_pin;
            repeat (h) @(posedge clk);
        end
    endtask
endmodule // usc_remote
`default_nettype wire

// ===== test/test_usart_clock_and_buffer_core.sv
// Purpose: register level bench of the core
// Assumes: zero wait apb, divisor small
// Notes: bit times measured on txd
`timescale 1ns/1ps
`default_nettype none
module test_usart_clock_and_buffer_core;
    import usc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, txd, rxd, transfer_clock_pin, xck_out, xck_oe, es;
    logic irq_tc, irq_te, irq_rc;
    int err_total = 0;
    int checked = 0;
    int n, k;
    usc_core u_usc_core (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .txd_out(txd), .rxd_in(rxd), .xck_in(transfer_clock_pin),
        .xck_out(xck_out), .xck_oe(xck_oe), .irq_tx_complete(irq_tc),
        .irq_tx_empty(irq_te), .irq_rx_complete(irq_rc));
    usc_remote u_usc_remote (.clk(pclk), .rxd(rxd), .transfer_clock_pin(transfer_clock_pin));
    // clock
    initial begin
        forever #50 pclk = ~pclk;
    end
    task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
        checked++;
        if (v !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", s, e, v);
        end
    endtask
    // one apb transfer, held until pready
    task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        es = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // send ff and time the start bit
    task automatic lowlen(input logic [31:0] c);
        xf(1'b1, REG_STAT, 32'h2);
        xf(1'b1, REG_DATA, 32'hFF);
        for (k = 0; k < 3000 && txd !== 1'b0; k++) @(posedge pclk);
        for (n = 0; n < 3000 && txd === 1'b0; n++) @(posedge pclk);
        xf(1'b1, REG_DATA, 32'hFF);
        for (k = 0; k < 3000 && irq_tc !== 1'b1; k++) @(posedge pclk);
        chk("start bit", n, c);
        chk("tx complete", irq_tc, 1);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #3000000;
        err_total++;
        test_done();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xf(1'b0, REG_CTRL, 32'h0);
        chk("ctrl", rd, 32'h0);
        xf(1'b0, 8'h20, 32'h0);
        chk("unmapped", {rd[30:0], es}, 32'h1);
        xf(1'b1, REG_DIV_HI, 32'h0);
        xf(1'b1, REG_DIV_LO, 32'h1);
        xf(1'b1, REG_CTRL, 32'h100);
        chk("empty irq", irq_te, 1);
        chk("async oe", xck_oe, 0);
        lowlen(32);
        xf(1'b1, REG_CTRL, 32'h102);
        xf(1'b1, REG_DIV_LO, 32'h2);
        lowlen(24);
        xf(1'b1, REG_CTRL, 32'h105);
        chk("master oe", xck_oe, 1);
        lowlen(6);
        for (k = 0; k < 3000 && xck_out !== 1'b0; k++) @(posedge pclk);
        for (k = 0; k < 3000 && xck_out !== 1'b1; k++) @(posedge pclk);
        for (n = 0; n < 3000 && xck_out === 1'b1; n++) @(posedge pclk);
        chk("xck half", n, 3);
        xf(1'b1, REG_CTRL, 32'h101);
        chk("slave oe", xck_oe, 0);
        fork
            u_usc_remote.clocks(32, 4);
            lowlen(8);
        join
        xf(1'b1, REG_CTRL, 32'h110);
        chk("off irq", irq_te, 0);
        xf(1'b1, REG_DIV_LO, 32'h1);
        xf(1'b1, REG_CTRL, 32'h200);
        u_usc_remote.send(8'hA5, 32);
        repeat (4) @(posedge pclk);
        chk("rx irq", irq_rc, 1);
        xf(1'b0, REG_DATA, 32'h0);
        chk("rx data", rd[8:0], 32'hA5);
        xf(1'b0, REG_STAT, 32'h0);
        chk("rx popped", rd[SB_RXC], 0);
        u_usc_remote.send(8'h11, 32);
        u_usc_remote.send(8'h22, 32);
        u_usc_remote.send(8'h33, 32);
        repeat (4) @(posedge pclk);
        xf(1'b0, REG_STAT, 32'h0);
        chk("rx status", rd[6:2], 32'h1);
        xf(1'b0, REG_DATA, 32'h0);
        chk("rx first", rd[8:0], 32'h11);
        xf(1'b0, REG_DATA, 32'h0);
        chk("rx second", rd[8:0], 32'h22);
        xf(1'b0, REG_DATA, 32'h0);
        chk("rx third", rd[8:0], 32'h33);
        test_done();
    end
endmodule // test_usart_clock_and_buffer_core
`default_nettype wire
